// ---- design/dea_pkg.sv ----
// distortion/error analyzer: shared constants, register map, carrier types
// assumes a 125 MHz core clock and a 32-bit APB register bus
package dea_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ    = 125_000_000; // core clock rate
	localparam int unsigned TICKS_BIT = 200;         // time-base ticks per unit interval
	localparam int unsigned AUTO_SEC  = 5;           // auto reset period in seconds
	localparam int unsigned AUTO_CYC  = AUTO_SEC * CLK_HZ;
	localparam int unsigned MAX_ERR   = 50;          // error count limit per interval
	localparam logic [7:0]  PH_LAST   = 8'(TICKS_BIT - 1);
	localparam logic [7:0]  PH_MID    = 8'(TICKS_BIT / 2);

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00; // mode and selection
	localparam logic [7:0] OFS_CMD  = 8'h04; // write-one commands
	localparam logic [7:0] OFS_DIST = 8'h08; // distortion read-out
	localparam logic [7:0] OFS_ERR  = 8'h0C; // error count read-out
	localparam logic [7:0] OFS_STAT = 8'h10; // sticky events, write one to clear
	localparam logic [7:0] OFS_MASK = 8'h14; // interrupt enables
	localparam logic [7:0] OFS_OPT0 = 8'h18; // six range-B divisors follow, one word each
	localparam int unsigned N_OPT   = 6;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CMD_CLR_DIST = 0;
	localparam int unsigned CMD_CLR_ERR  = 1;
	localparam int unsigned N_EVT        = 4;
	localparam int unsigned EV_PAR       = 0; // parity error
	localparam int unsigned EV_BIT       = 1; // pattern bit error
	localparam int unsigned EV_CHAR      = 2; // character received
	localparam int unsigned EV_IVL       = 3; // count interval ended
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [15:0] OPT_RST      = 16'h0041; // plain default divisor

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_A, SRC_B, SRC_EXT, SRC_RSV} src_e;
	typedef enum logic [1:0] {DM_PEAK, DM_BIAS, DM_END, DM_RSV} dmode_e;

	// control word, bit 31 downward
	typedef struct packed {
		logic [9:0] rsv;
		logic       ext_bsync; // bit phase from external bit sync
		logic [2:0] ivl_sel;   // 0..4 decades, others unbounded
		logic       prbs;      // pattern: pseudo random, else reversal
		logic       bit_err;   // count bit errors, else parity errors
		logic       auto_rst;  // automatic read-out reset
		logic [2:0] trans_sel; // 0 all transitions, n nth only
		dmode_e     dmode;     // distortion component
		logic       odd_par;   // odd parity, else even
		logic       sync_mode; // synchronous input
		logic [1:0] level;     // code level minus five
		logic [3:0] rate;      // range A rate or range B slot
		src_e       src;       // time base source
	} ctrl_s;

	// one measured transition
	typedef struct packed {
		logic       marking; // sense of the displacement
		logic [7:0] disp;    // half-percent units
	} disp_s;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// core clocks per 200x tick for range A; rates held as twice the baud
	function automatic logic [15:0] rate_div(input logic [3:0] idx);
		int unsigned b2;
		b2 = 75;
		unique case (idx)
			4'd0: b2 = 75;
			4'd1: b2 = 100;
			4'd2: b2 = 150;
			4'd3: b2 = 300;
			4'd4: b2 = 600;
			4'd5: b2 = 1200;
			4'd6: b2 = 2400;
			4'd7: b2 = 4800;
			4'd8: b2 = 9600;
			default: b2 = 19200;
		endcase
		return 16'((2 * CLK_HZ) / (b2 * TICKS_BIT));
	endfunction : rate_div

	// bits per count interval; zero means unbounded
	function automatic logic [19:0] ivl_bits(input logic [2:0] sel);
		unique case (sel)
			3'd0: return 20'd100;
			3'd1: return 20'd1000;
			3'd2: return 20'd10000;
			3'd3: return 20'd100000;
			3'd4: return 20'd1000000;
			default: return 20'd0;
		endcase
	endfunction : ivl_bits

endpackage : dea_pkg

// ---- design/dea_tick_gen.sv ----
// 200x time-base tick generator for the analyzer
// assumes the external time base is synchronous to core_clk_i
`timescale 1ns/1ps
module dea_tick_gen (
	input  wire logic        core_clk_i, // core clock
	input  wire logic        nrst_i,     // async reset, active low
	input  wire logic        ext_sel_i,  // use external time base
	input  wire logic [15:0] div_i,      // core clocks per tick
	input  wire logic        ext_tb_i,   // external 200x square wave
	output logic             tick_o      // one-cycle tick pulse
);

	logic [15:0] cnt_ff;   // divider count
	logic        ext_q_ff; // previous external level
	logic        tick_ff;  // registered tick

	// ----------------------------------------------------------------
	// divider and external edge
	// ----------------------------------------------------------------
	// a divisor of zero or one degrades to a tick every cycle, never a stall
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ff   <= 16'h0000;
			ext_q_ff <= 1'b0;
			tick_ff  <= 1'b0;
		end else begin
			ext_q_ff <= ext_tb_i;
			if (ext_sel_i) begin
				cnt_ff  <= 16'h0000;
				tick_ff <= ext_tb_i & ~ext_q_ff; // rising edge of the 200x wave
			end else if (cnt_ff + 16'h0001 >= div_i) begin
				cnt_ff  <= 16'h0000;
				tick_ff <= 1'b1;
			end else begin
				cnt_ff  <= cnt_ff + 16'h0001;
				tick_ff <= 1'b0;
			end
		end
	end

	assign tick_o = tick_ff;

endmodule : dea_tick_gen

// ---- design/dea_analyzer.sv ----
// telegraph distortion and error analyzer core with an APB register file
// assumes sig_i, ext_tb_i and ext_bsync_i are synchronous to core_clk_i
`timescale 1ns/1ps
module dea_analyzer #(
	parameter int unsigned AUTO_CYC = dea_pkg::AUTO_CYC // five seconds of core clocks
) (
	input  wire logic        core_clk_i,  // core clock
	input  wire logic        nrst_i,      // async reset, active low
	input  wire logic        psel,        // apb select
	input  wire logic        penable,     // apb enable
	input  wire logic        pwrite,      // apb direction
	input  wire logic [7:0]  paddr,       // apb byte address
	input  wire logic [31:0] pwdata,      // apb write data
	output logic [31:0]      prdata,      // apb read data
	output logic             pready,      // apb ready
	output logic             pslverr,     // apb error on unmapped address
	input  wire logic        sig_i,       // signal under test, 1 = mark
	input  wire logic        ext_tb_i,    // external 200x time base
	input  wire logic        ext_bsync_i, // external bit sync
	output logic             pattern_o,   // test pattern
	output logic             err_pulse_o, // error pulse
	output logic             bit_sync_o,  // bit timing square wave
	output logic             char_sync_o, // character sync pulse
	output logic             alarm_o,     // parity alarm lamp
	output logic             irq_o        // interrupt, level
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	typedef enum logic {FR_IDLE, FR_BUSY} frame_e;

	dea_pkg::ctrl_s  ctrl_ff;                 // control word
	logic [15:0]     opt_ff [dea_pkg::N_OPT]; // range B divisors
	logic [3:0]      stat_ff, mask_ff;        // sticky events and enables
	logic [31:0]     prdata_ff;               // read data
	logic            pready_ff, pslverr_ff;   // bus answer
	logic            irq_ff;                  // interrupt level
	logic [15:0]     div;                     // selected divisor
	logic            tick;                    // 200x tick
	logic [7:0]      phase_ff;                // tick within unit interval
	logic            sig_q_ff, bs_q_ff;       // previous levels
	logic            aligned_ff;              // sync mode phase known
	frame_e          fr_ff;                   // start-stop frame state
	logic [3:0]      elem_ff;                 // element index in frame
	logic [2:0]      tr_ff;                   // transition index in frame
	logic [7:0]      chr_ff;                  // received data bits
	dea_pkg::disp_s  dist_ff;                 // held distortion result
	logic            dvalid_ff;               // result holds a measurement
	logic [8:0]      hist_ff;                 // received bit history
	logic [3:0]      fill_ff;                 // history warm-up count
	logic [8:0]      pat_ff;                  // pattern generator state
	logic [5:0]      ecnt_ff;                 // error count
	logic [19:0]     bits_ff;                 // bits in interval
	logic            done_ff;                 // interval ended, count held
	logic [31:0]     wait_ff;                 // auto reset timer
	logic            err_ff, chs_ff, bsy_ff;  // output pulses and levels
	logic            alarm_ff;                // parity alarm

	logic            wr, rd, chg, fall, late, mid, bit_end, samp, stop_elem;
	logic [3:0]      last_elem;
	logic            par_err, bit_err, err_evt, ivl_end, auto_fire;
	dea_pkg::disp_s  meas;
	logic [3:0]      bnd;
	logic            qual;
	logic [3:0]      evt;
	logic            clr_dist, clr_err;

	// ----------------------------------------------------------------
	// apb slave: one wait state, writes act at the ready edge
	// ----------------------------------------------------------------
	assign wr       = psel & penable & pready_ff & pwrite;
	assign rd       = psel & penable & ~pready_ff & ~pwrite;
	assign clr_dist = wr & (paddr == dea_pkg::OFS_CMD) & pwdata[dea_pkg::CMD_CLR_DIST];
	assign clr_err  = wr & (paddr == dea_pkg::OFS_CMD) & pwdata[dea_pkg::CMD_CLR_ERR];

	// ready, error and read data are registered so every bus output is a flop
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel & penable & ~pready_ff;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
			if (psel & penable & ~pready_ff) begin
				if (paddr > dea_pkg::OFS_OPT0 + 8'(4 * (dea_pkg::N_OPT - 1)) || paddr[1:0] != 2'b00)
					pslverr_ff <= 1'b1; // unmapped word
				else if (paddr >= dea_pkg::OFS_OPT0)
					prdata_ff <= rd ? {16'h0000, opt_ff[3'((paddr - dea_pkg::OFS_OPT0) >> 2)]} : 32'h0000_0000;
				else if (rd) begin
					unique case (paddr)
						dea_pkg::OFS_CTRL: prdata_ff <= ctrl_ff;
						dea_pkg::OFS_DIST: prdata_ff <= {22'h00_0000, dvalid_ff, dist_ff};
						dea_pkg::OFS_ERR:  prdata_ff <= {23'h00_0000, done_ff, 2'b00, ecnt_ff};
						dea_pkg::OFS_STAT: prdata_ff <= {28'h000_0000, stat_ff};
						dea_pkg::OFS_MASK: prdata_ff <= {28'h000_0000, mask_ff};
						default:           prdata_ff <= 32'h0000_0000; // command reads zero
					endcase
				end
			end
		end
	end

	// control, mask and divisor registers
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_ff <= dea_pkg::CTRL_RST;
			mask_ff <= 4'h0;
			for (int i = 0; i < dea_pkg::N_OPT; i++)
				opt_ff[i] <= dea_pkg::OPT_RST;
		end else if (wr) begin
			if (paddr == dea_pkg::OFS_CTRL)
				ctrl_ff <= pwdata;
			if (paddr == dea_pkg::OFS_MASK)
				mask_ff <= pwdata[3:0];
			for (int i = 0; i < dea_pkg::N_OPT; i++)
				if (paddr == dea_pkg::OFS_OPT0 + 8'(4 * i))
					opt_ff[i] <= pwdata[15:0];
		end
	end

	// sticky events: a set in the clearing cycle wins
	assign evt = {ivl_end, samp & stop_elem & fr_ff == FR_BUSY, bit_err, par_err};
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			stat_ff <= 4'h0;
			irq_ff  <= 1'b0;
		end else begin
			stat_ff <= (stat_ff & ~((wr && paddr == dea_pkg::OFS_STAT) ? pwdata[3:0] : 4'h0)) | evt;
			irq_ff  <= |(stat_ff & mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// time base and bit phase
	// ----------------------------------------------------------------
	// range A uses the fixed table, range B a user divisor per slot
	assign div = (ctrl_ff.src == dea_pkg::SRC_B) ?
		opt_ff[(ctrl_ff.rate < 4'(dea_pkg::N_OPT)) ? 3'(ctrl_ff.rate) : 3'd0] :
		dea_pkg::rate_div(ctrl_ff.rate);

	dea_tick_gen u_tick (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.ext_sel_i  (ctrl_ff.src == dea_pkg::SRC_EXT),
		.div_i      (div),
		.ext_tb_i   (ext_tb_i),
		.tick_o     (tick)
	);

	assign chg     = sig_i != sig_q_ff;
	assign fall    = chg & ~sig_i;
	assign mid     = tick & (phase_ff == dea_pkg::PH_MID);
	assign bit_end = tick & (phase_ff == dea_pkg::PH_LAST);

	// phase restarts at a start edge, at the first sync-mode edge, or at bit sync
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			phase_ff   <= 8'h00;
			sig_q_ff   <= 1'b1;
			bs_q_ff    <= 1'b0;
			aligned_ff <= 1'b0;
		end else begin
			sig_q_ff <= sig_i;
			bs_q_ff  <= ext_bsync_i;
			if (ctrl_ff.ext_bsync & ext_bsync_i & ~bs_q_ff) begin
				phase_ff   <= 8'h00;
				aligned_ff <= 1'b1;
			end else if ((~ctrl_ff.sync_mode & fr_ff == FR_IDLE & fall) |
			             (ctrl_ff.sync_mode & ~aligned_ff & chg)) begin
				phase_ff   <= 8'h00;
				aligned_ff <= ctrl_ff.sync_mode;
			end else if (tick)
				phase_ff <= bit_end ? 8'h00 : phase_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// frame tracking and bit sampling
	// ----------------------------------------------------------------
	assign last_elem = 4'd6 + {2'b00, ctrl_ff.level}; // stop element index
	assign samp      = mid & (ctrl_ff.sync_mode | fr_ff == FR_BUSY);
	assign stop_elem = elem_ff == last_elem;

	// start, data and stop elements, sampled mid-interval
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fr_ff   <= FR_IDLE;
			elem_ff <= 4'h0;
			chr_ff  <= 8'h00;
		end else if (ctrl_ff.sync_mode) begin
			fr_ff <= FR_IDLE;
			if (samp) begin
				chr_ff  <= {sig_i, chr_ff[7:1]};
				elem_ff <= (elem_ff == 4'd7) ? 4'h0 : elem_ff + 4'h1;
			end
		end else begin
			unique case (fr_ff)
				FR_IDLE: begin
					elem_ff <= 4'h0;
					if (fall)
						fr_ff <= FR_BUSY;
				end
				FR_BUSY: begin
					if (samp) begin
						if (elem_ff == 4'h0 && sig_i)
							fr_ff <= FR_IDLE; // start element did not hold
						else if (stop_elem)
							fr_ff <= FR_IDLE;
						else if (elem_ff != 4'h0)
							chr_ff <= {sig_i, chr_ff[7:1]} >> (2'd3 - ctrl_ff.level);
					end
					if (bit_end)
						elem_ff <= elem_ff + 4'h1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// distortion measurement
	// ----------------------------------------------------------------
	// each tick is half a percent; a late edge lengthens the element before it
	assign late         = phase_ff < dea_pkg::PH_MID;
	assign meas.disp    = late ? phase_ff : 8'(dea_pkg::TICKS_BIT) - phase_ff;
	assign meas.marking = fall == late;
	assign bnd          = late ? elem_ff : elem_ff + 4'h1;

	// component and transition position gating
	always_comb begin
		qual = chg & (ctrl_ff.sync_mode ? aligned_ff : fr_ff == FR_BUSY);
		unique case (ctrl_ff.dmode)
			dea_pkg::DM_BIAS: qual = qual & ~(~ctrl_ff.sync_mode & bnd == last_elem);
			dea_pkg::DM_END:  qual = qual & ~ctrl_ff.sync_mode & bnd == last_elem;
			default:          qual = qual; // peak takes all
		endcase
		if (ctrl_ff.trans_sel != 3'd0)
			qual = qual & (tr_ff + 3'd1 == ctrl_ff.trans_sel);
	end

	// largest displacement since clear, with its sense
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dist_ff   <= '0;
			dvalid_ff <= 1'b0;
			tr_ff     <= 3'd0;
		end else begin
			if (chg)
				tr_ff <= (fr_ff == FR_IDLE || ctrl_ff.sync_mode) ? 3'd0 : tr_ff + 3'd1;
			if (qual && (!dvalid_ff || meas.disp > dist_ff.disp)) begin
				dist_ff   <= meas;
				dvalid_ff <= 1'b1;
			end else if (clr_dist || (auto_fire && ctrl_ff.dmode == dea_pkg::DM_PEAK)) begin
				dist_ff   <= '0;
				dvalid_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// parity and pattern bit checks
	// ----------------------------------------------------------------
	// parity only means something on eight-level characters
	assign par_err = samp & stop_elem & fr_ff == FR_BUSY & ~ctrl_ff.sync_mode &
		ctrl_ff.level == 2'd3 & ((^chr_ff) != ctrl_ff.odd_par);

	// pseudo random is self-synchronising off received history, reversal checks toggling
	assign bit_err = samp & ~(~ctrl_ff.sync_mode & (elem_ff == 4'h0 | stop_elem)) & fill_ff == 4'd9 &
		(sig_i != (ctrl_ff.prbs ? hist_ff[8] ^ hist_ff[4] : ~hist_ff[0]));

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hist_ff <= 9'h000;
			fill_ff <= 4'h0;
		end else if (samp && (ctrl_ff.sync_mode || (elem_ff != 4'h0 && !stop_elem))) begin
			hist_ff <= {hist_ff[7:0], sig_i};
			if (fill_ff != 4'd9)
				fill_ff <= fill_ff + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// error counter and automatic reset
	// ----------------------------------------------------------------
	assign err_evt   = ~done_ff & (ctrl_ff.bit_err ? bit_err : par_err);
	assign ivl_end   = samp & ~done_ff & dea_pkg::ivl_bits(ctrl_ff.ivl_sel) != 20'd0 &
		bits_ff + 20'd1 == dea_pkg::ivl_bits(ctrl_ff.ivl_sel);
	assign auto_fire = ctrl_ff.auto_rst & wait_ff + 32'd1 >= AUTO_CYC;

	// count saturates at the limit; a finished interval holds until a clear command or an auto reset, and auto reset skips parity counting in sync mode
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ecnt_ff <= 6'd0;
			bits_ff <= 20'd0;
			done_ff <= 1'b0;
		end else if (clr_err || (auto_fire && done_ff && ctrl_ff.bit_err | ~ctrl_ff.sync_mode)) begin
			ecnt_ff <= 6'd0;
			bits_ff <= 20'd0;
			done_ff <= 1'b0;
		end else begin
			if (err_evt && ecnt_ff != 6'(dea_pkg::MAX_ERR))
				ecnt_ff <= ecnt_ff + 6'd1;
			if (samp && !done_ff)
				bits_ff <= bits_ff + 20'd1;
			if (ivl_end)
				done_ff <= 1'b1;
		end
	end

	// one timer: free-running in peak mode, started by interval end when counting
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			wait_ff <= 32'd0;
		else if (!ctrl_ff.auto_rst || auto_fire)
			wait_ff <= 32'd0;
		else if (done_ff || ctrl_ff.dmode == dea_pkg::DM_PEAK)
			wait_ff <= wait_ff + 32'd1;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pat_ff   <= 9'h1FF;
			err_ff   <= 1'b0;
			chs_ff   <= 1'b0;
			bsy_ff   <= 1'b0;
			alarm_ff <= 1'b0;
		end else begin
			if (bit_end)
				pat_ff <= ctrl_ff.prbs ? {pat_ff[7:0], pat_ff[8] ^ pat_ff[4]} : {8'h00, ~pat_ff[0]};
			err_ff <= bit_err | par_err;
			chs_ff <= samp & (ctrl_ff.sync_mode ? elem_ff == 4'd7 : stop_elem);
			bsy_ff <= phase_ff < dea_pkg::PH_MID;
			if (par_err)
				alarm_ff <= 1'b1;
			else if (clr_err)
				alarm_ff <= 1'b0;
		end
	end

	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign pattern_o   = pat_ff[0];
	assign err_pulse_o = err_ff;
	assign bit_sync_o  = bsy_ff;
	assign char_sync_o = chs_ff;
	assign alarm_o     = alarm_ff;
	assign irq_o       = irq_ff;

endmodule : dea_analyzer

// ---- verif/dea_analyzer_props.sv ----
// checker: apb timing, output pulse widths, alarm hold
// assumes one core clock and the active-low async reset
`timescale 1ns/1ps
module dea_analyzer_props #(
	parameter int unsigned AUTO_CYC = 2000 // auto reset period
) (
	input wire logic        core_clk_i,
	input wire logic        nrst_i,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        err_pulse_o,
	input wire logic        char_sync_o,
	input wire logic        alarm_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// clear-errors command completing at this edge
	wire clr_w = psel & penable & pready & pwrite & (paddr == 8'h04) & pwdata[1];
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("ready missing after wait state");
	property p_in_acc; pready |-> psel && penable && $past(psel); endproperty
	a_in_acc: assert property (p_in_acc) else $error("ready outside access");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready longer than a cycle");
	property p_err; pready |-> pslverr == (paddr > 8'h2C || paddr[1:0] != 2'b00); endproperty
	a_err: assert property (p_err) else $error("slave error wrong for address");
	property p_rd0; !pready |-> prdata == 32'h0000_0000; endproperty
	a_rd0: assert property (p_rd0) else $error("read data outside answer");
	property p_epl; err_pulse_o |=> !err_pulse_o; endproperty
	a_epl: assert property (p_epl) else $error("error pulse too long");
	property p_cs; char_sync_o |=> !char_sync_o [*2]; endproperty
	a_cs: assert property (p_cs) else $error("char sync too long");
	property p_alm; alarm_o && !clr_w |=> alarm_o; endproperty
	a_alm: assert property (p_alm) else $error("alarm dropped uncommanded");
	property p_aclr; clr_w |=> !alarm_o || err_pulse_o; endproperty
	a_aclr: assert property (p_aclr) else $error("alarm not cleared");
	c_err: cover property (err_pulse_o);
	c_cs: cover property (char_sync_o);
	c_slv: cover property (pslverr);
endmodule : dea_analyzer_props
bind dea_analyzer dea_analyzer_props #(.AUTO_CYC(AUTO_CYC)) dea_analyzer_props_inst (.core_clk_i(core_clk_i),
	.nrst_i(nrst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .err_pulse_o(err_pulse_o),
	.char_sync_o(char_sync_o), .alarm_o(alarm_o));

// ---- verif/dea_line_model.sv ----
// line model: start-stop sender, 200x time base, bit sync
// assumes 400 core clocks per element (a tick every two clocks)
`timescale 1ns/1ps
module dea_line_model (
	input  wire logic core_clk_i, // core clock
	output logic      sig_o,      // line, idles mark
	output logic      tb_o,       // 200x square wave
	output logic      bs_o        // 1x bit sync square wave
);
	int unsigned cnt; // clocks within a bit
	initial begin
		sig_o = 1'b1;
		tb_o = 1'b0;
		bs_o = 1'b0;
		cnt = 0;
	end
	// time base free runs so the analyzer never loses ticks
	always @(posedge core_clk_i) begin
		tb_o <= ~tb_o;
		cnt <= (cnt == 399) ? 0 : cnt + 1;
		bs_o <= (cnt < 200);
	end
	// one frame: start, nd elements lsb first, stop
	task automatic send(input logic [7:0] b, input int nd);
		int i;
		for (i = -1; i <= nd; i++) begin
			sig_o <= (i < 0) ? 1'b0 : (i == nd) ? 1'b1 : b[i[2:0]];
			repeat (400) @(posedge core_clk_i);
		end
	endtask : send
endmodule : dea_line_model

// ---- verif/tb.sv ----
// testbench: apb master, line model, scenario tasks
// assumes ext time base mode so an eight-level frame takes 4000 clocks
`timescale 1ns/1ps
module tb;
	logic        core_clk_i = 0, nrst_i = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, er, sig, tbs, bsy, pat, epl, bsq, csy, alm, irq, bs_q, pt_q;
	int          n_fail = 0, tests_run = 0, n_err = 0, n_chr = 0, n_bs = 0, n_pt = 0;
	always #4 core_clk_i = ~core_clk_i;
	dea_line_model dea_line_model_inst (.core_clk_i(core_clk_i), .sig_o(sig), .tb_o(tbs), .bs_o(bsy));
	dea_analyzer #(.AUTO_CYC(2000)) dea_analyzer_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sig_i(sig), .ext_tb_i(tbs), .ext_bsync_i(bsy), .pattern_o(pat),
		.err_pulse_o(epl), .bit_sync_o(bsq), .char_sync_o(csy), .alarm_o(alm), .irq_o(irq));
	// pulse and edge counters
	always @(posedge core_clk_i) begin
		n_err <= n_err + int'(epl === 1'b1);
		n_chr <= n_chr + int'(csy === 1'b1);
		n_bs <= n_bs + int'(bsq === 1'b1 && bs_q === 1'b0);
		n_pt <= n_pt + int'(pat !== pt_q);
		bs_q <= bsq;
		pt_q <= pat;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// one apb transfer; held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_i); // idle cycle so the next setup never re-raises psel in this step
		if (n >= 20) begin
			n_fail++;
			give_verdict();
		end
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string m);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e, m);
	endtask : rdchk
	task automatic t_regs();
		rdchk(8'h00, 32'h0000_0000, "ctrl reset");
		rdchk(8'h18, 32'h0000_0041, "slot reset");
		apb(1'b1, 8'h2C, 32'h0000_1234);
		rdchk(8'h2C, 32'h0000_1234, "slot write");
		rdchk(8'h30, 32'h0000_0000, "unmapped data");
		chk(32'(er), 32'h0000_0001, "unmapped error");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_parity();
		apb(1'b1, 8'h14, 32'h0000_0001);
		apb(1'b1, 8'h00, 32'h0000_00C2); // external base, eight-level, even
		dea_line_model_inst.send(8'h01, 8);
		chk(n_err, 1, "parity pulse");
		chk(n_chr, 1, "char pulse");
		chk(32'(alm), 1, "alarm");
		chk(32'(irq), 1, "irq");
		rdchk(8'h0C, 32'h0000_0001, "count");
		dea_line_model_inst.send(8'h55, 8); // good parity, alternating so the reversal check stays quiet
		chk(n_err, 1, "no bit error on reversal");
		rdchk(8'h0C, 32'h0000_0001, "count held");
		apb(1'b1, 8'h10, 32'h0000_000F);
		repeat (2) @(posedge core_clk_i);
		chk(32'(irq), 0, "irq clear");
		apb(1'b1, 8'h04, 32'h0000_0002);
		rdchk(8'h0C, 32'h0000_0000, "count cleared");
		chk(32'(alm), 0, "alarm cleared");
		$display("t_parity done");
	endtask : t_parity
	// five-level frame with odd weight: parity is not checked here
	task automatic t_level();
		apb(1'b1, 8'h00, 32'h0000_0002);
		dea_line_model_inst.send(8'h15, 5); // still alternating, so no bit error pulses either
		chk(n_err, 1, "no parity on five-level");
		chk(n_chr, 3, "five-level frame");
		$display("t_level done");
	endtask : t_level
	task automatic t_clocks();
		int b0;
		int p0;
		b0 = n_bs;
		p0 = n_pt;
		repeat (4000) @(posedge core_clk_i);
		chk(32'(n_bs - b0 inside {[9:11]}), 1, "bit sync rate");
		chk(32'(n_pt - p0 inside {[9:11]}), 1, "reversal rate");
		$display("t_clocks done");
	endtask : t_clocks
	task automatic t_dist();
		apb(1'b1, 8'h00, 32'h0000_00C2);
		apb(1'b1, 8'h04, 32'h0000_0001);
		rdchk(8'h08, 32'h0000_0000, "dist cleared");
		dea_line_model_inst.send(8'h01, 8);
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(32'(rd[9]), 1, "dist valid");
		chk(32'(rd[7:0] <= 8'h04), 1, "clean line small");
		apb(1'b1, 8'h00, 32'h0000_80C2); // peak with auto reset
		repeat (2100) @(posedge core_clk_i);
		rdchk(8'h08, 32'h0000_0000, "auto cleared");
		$display("t_dist done");
	endtask : t_dist
	initial begin
		repeat (3) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		@(posedge core_clk_i);
		t_regs();
		t_parity();
		t_level();
		t_clocks();
		t_dist();
		give_verdict();
	end
endmodule : tb
